// ### rtl/driver_fault_status_map.vh
// Register map, field positions and timing counts of the driver status logic
`ifndef DRIVER_FAULT_STATUS_MAP_VH
`define DRIVER_FAULT_STATUS_MAP_VH
`define DRIVER_FAULT_STATUS_ADDR 7'h6f
`define AMPLITUDE_OFFSET_ADDR    7'h70
`define BIT_STANDSTILL           31
`define BIT_OPEN_B               30
`define BIT_OPEN_A               29
`define BIT_SHORT_B              28
`define BIT_SHORT_A              27
`define BIT_OT_WARN              26
`define BIT_OT_SHUT              25
`define BIT_STALL                24
`define AMPLITUDE_OFFSET_RESET   8'h1e
`define STANDSTILL_CYCLES        21'h100000
`endif

// ### rtl/sync2.v
// Two-stage synchroniser for one level from outside the clock domain
`timescale 1ns/100ps
module sync2 #(
  parameter WIDTH = 1
) (
  // Clock and reset
  input  wire             i_mclk,
  input  wire             i_rst,
  // Level in from outside and level out
  input  wire [WIDTH-1:0] i_d,
  output wire [WIDTH-1:0] o_q
);
  reg [WIDTH-1:0] meta_reg;
  reg [WIDTH-1:0] q_reg;

  // First stage feeds only the second
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      meta_reg <= {WIDTH{1'b0}};
      q_reg    <= {WIDTH{1'b0}};
    end else begin
      meta_reg <= i_d;
      q_reg    <= meta_reg;
    end
  end

  assign o_q = q_reg;
endmodule // sync2

// ### rtl/driver_status_flags.v
// Driver diagnostic status flags, fault disable and amplitude offset floor
`timescale 1ns/100ps
`include "driver_fault_status_map.vh"
// Notes on behaviour
// RULE1 - Standstill bit 31 sets 2^20 clocks after the last step pulse.
// RULE2 - Bit 30 flags open load on coil B, bit 29 on coil A.
// RULE3 - Open-load flags never disable or alter bridge drive.
// RULE4 - Ground short sets bit 28 (B) or 27 (A) and disables drivers.
// RULE5 - Short flags and disable hold until off time is zero or enable pin high.
// RULE6 - Bit 26 shows pre-warning temperature exceeded, one flag for both bridges.
// RULE7 - Bit 25 marks shutdown; drivers stay off until pre-warning clears.
// RULE8 - Bit 24 sets on zero load value or stall in load-speed mode.
// RULE9 - Offset zero: current scaling never goes below lower measurement threshold.
// RULE10 - Offset above zero: scaling may reach duties below that threshold.
// RULE11 - Host should use zero offset only with widely varying supply voltage.
// RULE12 - Host writes offset with autoscale off, then autoscale, then quiet mode.
// RULE13 - Offset is eight bits, 0 to 255, reset value 30.
// RULE14 - Stall detection compares load value against zero; larger means lighter load.
// RULE15 - Bits 23 to 21 read zero; reading has no side effects.
// RULE16 - All flags update on the device clock for a coherent snapshot.
module driver_status_flags #(
  parameter STANDSTILL_CYCLES = `STANDSTILL_CYCLES,
  parameter LOAD_WIDTH        = 10
) (
  // Clock and reset
  input  wire                  i_mclk,
  input  wire                  i_rst,
  // Pins and analog comparators from outside the clock domain
  input  wire                  i_step,
  input  wire                  i_driver_enable_low_pin,
  input  wire                  i_open_load_a,
  input  wire                  i_open_load_b,
  input  wire                  i_ground_short_a,
  input  wire                  i_ground_short_b,
  input  wire                  i_overtemp_warn,
  input  wire                  i_overtemp_limit,
  // Same-domain chopper inputs
  input  wire [LOAD_WIDTH-1:0] i_load_measurement_value,
  input  wire                  i_load_valid,
  input  wire                  i_speed_mode,
  input  wire                  i_speed_mode_stall,
  input  wire [3:0]            i_chopper_off_time,
  input  wire [7:0]            i_auto_scale,
  input  wire [7:0]            i_lower_threshold,
  // Register write port
  input  wire                  i_wr,
  input  wire [6:0]            i_addr,
  input  wire [7:0]            i_wdata,
  // Register read port
  input  wire                  i_rd,
  output reg  [31:0]           o_rdata,
  // Driver outputs
  output reg                   o_bridge_enable,
  output reg  [7:0]            o_pwm_amplitude,
  output reg  [7:0]            o_amplitude_offset
);
  // Synchronised copies of the outside levels
  wire        step_s;
  wire        pin_off_s;
  wire        open_a_s;
  wire        open_b_s;
  wire        short_a_s;
  wire        short_b_s;
  wire        warn_s;
  wire        shut_s;
  // Standstill timer state
  reg         step_d_reg;
  reg  [20:0] idle_cnt_reg;
  reg         standstill_reg;
  // Status flag registers
  reg         coil_a_ground_short_reg;
  reg         coil_b_ground_short_reg;
  reg         overtemp_shutdown_flag_reg;
  reg         stall_detected_flag_reg;
  reg         open_a_reg;
  reg         open_b_reg;
  reg         warn_reg;
  // Combinational terms
  wire        short_clear;
  wire        stall_now;
  wire [31:0] status_word;
  wire [7:0]  amp_next;

  // Step pin; every outside level passes two flops before use
  sync2 u_s_step (
    .i_mclk (i_mclk),
    .i_rst  (i_rst),
    .i_d    (i_step),
    .o_q    (step_s)
  );

  // Enable pin, high turns the bridges off
  sync2 u_s_pin_off (
    .i_mclk (i_mclk),
    .i_rst  (i_rst),
    .i_d    (i_driver_enable_low_pin),
    .o_q    (pin_off_s)
  );

  // Open-load comparators, one per coil
  sync2 u_s_open_a (
    .i_mclk (i_mclk),
    .i_rst  (i_rst),
    .i_d    (i_open_load_a),
    .o_q    (open_a_s)
  );
  sync2 u_s_open_b (
    .i_mclk (i_mclk),
    .i_rst  (i_rst),
    .i_d    (i_open_load_b),
    .o_q    (open_b_s)
  );

  // Ground-short comparators, one per coil
  sync2 u_s_short_a (
    .i_mclk (i_mclk),
    .i_rst  (i_rst),
    .i_d    (i_ground_short_a),
    .o_q    (short_a_s)
  );
  sync2 u_s_short_b (
    .i_mclk (i_mclk),
    .i_rst  (i_rst),
    .i_d    (i_ground_short_b),
    .o_q    (short_b_s)
  );

  // Temperature comparators; no debounce, so noise toggles the warning flag, while the shutdown flag holds as long as warn_s is high
  sync2 u_s_warn (
    .i_mclk (i_mclk),
    .i_rst  (i_rst),
    .i_d    (i_overtemp_warn),
    .o_q    (warn_s)
  );
  sync2 u_s_shut (
    .i_mclk (i_mclk),
    .i_rst  (i_rst),
    .i_d    (i_overtemp_limit),
    .o_q    (shut_s)
  );

  // Release of latched shorts: off time zero or enable pin high
  assign short_clear = (i_chopper_off_time == 4'h0) | pin_off_s; // RULE5

  // Standstill timer restarts on each rising step edge
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      step_d_reg     <= 1'b0;
      idle_cnt_reg   <= 21'h000000;
      standstill_reg <= 1'b0;
    end else begin
      step_d_reg <= step_s;
      if (step_s & ~step_d_reg) begin
        idle_cnt_reg   <= 21'h000000;
        standstill_reg <= 1'b0;
      end else if (idle_cnt_reg == STANDSTILL_CYCLES[20:0] - 21'h000001) begin
        standstill_reg <= 1'b1; // RULE1
      end else begin
        idle_cnt_reg <= idle_cnt_reg + 21'h000001;
      end
    end
  end

  // Informational levels follow their synchronised inputs
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      open_a_reg <= 1'b0;
      open_b_reg <= 1'b0;
      warn_reg   <= 1'b0;
    end else begin
      open_a_reg <= open_a_s; // RULE2
      open_b_reg <= open_b_s; // RULE2
      warn_reg   <= warn_s; // RULE6
    end
  end

  // Zero load value means the highest load, taken as a stall
  assign stall_now = (i_load_valid & (i_load_measurement_value == {LOAD_WIDTH{1'b0}}))
                     | (i_speed_mode & i_speed_mode_stall); // RULE8 RULE14

  // Latched shorts and shutdown, stall flag follows stall_now; a new short wins over a clear in the same cycle
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      coil_a_ground_short_reg    <= 1'b0;
      coil_b_ground_short_reg    <= 1'b0;
      overtemp_shutdown_flag_reg <= 1'b0;
      stall_detected_flag_reg    <= 1'b0;
    end else begin
      coil_a_ground_short_reg <= short_a_s | (coil_a_ground_short_reg & ~short_clear); // RULE4
      coil_b_ground_short_reg <= short_b_s | (coil_b_ground_short_reg & ~short_clear); // RULE4
      // Shutdown holds until the warning has also cooled off
      overtemp_shutdown_flag_reg <= shut_s | (overtemp_shutdown_flag_reg & warn_s); // RULE7
      stall_detected_flag_reg    <= stall_now; // RULE8
    end
  end

  // Status word; reserved bits zero, reading changes nothing
  assign status_word = {standstill_reg, open_b_reg, open_a_reg, coil_b_ground_short_reg,
                        coil_a_ground_short_reg, warn_reg, overtemp_shutdown_flag_reg,
                        stall_detected_flag_reg, 3'h0, 21'h000000}; // RULE15

  // Offset floor: zero offset clamps at the measurement threshold
  assign amp_next = ((o_amplitude_offset == 8'h00) && (i_auto_scale < i_lower_threshold))
                    ? i_lower_threshold // RULE9
                    : i_auto_scale; // RULE10

  // Registers, bridge enable and snapshot read, all on one clock
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_amplitude_offset <= `AMPLITUDE_OFFSET_RESET; // RULE13
      o_rdata            <= 32'h00000000;
      o_bridge_enable    <= 1'b0;
      o_pwm_amplitude    <= 8'h00;
    end else begin
      if (i_wr && (i_addr == `AMPLITUDE_OFFSET_ADDR))
        o_amplitude_offset <= i_wdata; // RULE13
      if (i_rd) begin
        if (i_addr == `DRIVER_FAULT_STATUS_ADDR)
          o_rdata <= status_word; // RULE16
        else
          o_rdata <= 32'h00000000;
      end
      // Open load is not a term here on purpose
      o_bridge_enable <= ~pin_off_s & (i_chopper_off_time != 4'h0) & ~coil_a_ground_short_reg
                         & ~coil_b_ground_short_reg
                         & ~overtemp_shutdown_flag_reg; // RULE3 RULE4 RULE7
      o_pwm_amplitude <= amp_next;
    end
  end
endmodule // driver_status_flags

// ### verif/status_flags_asserts.sv
// Port checks of the driver status flags
`timescale 1ns/100ps
module status_flags_asserts (
  // Clock and reset
  input wire        i_mclk,
  input wire        i_rst,
  // Pins and comparators
  input wire        i_driver_enable_low_pin,
  input wire        i_ground_short_a,
  input wire        i_ground_short_b,
  input wire        i_overtemp_limit,
  // Chopper inputs
  input wire [3:0]  i_chopper_off_time,
  input wire [7:0]  i_auto_scale,
  input wire [7:0]  i_lower_threshold,
  // Register port
  input wire        i_wr,
  input wire        i_rd,
  input wire [6:0]  i_addr,
  input wire [7:0]  i_wdata,
  // Design outputs
  input wire [31:0] o_rdata,
  input wire        o_bridge_enable,
  input wire [7:0]  o_pwm_amplitude,
  input wire [7:0]  o_amplitude_offset
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  // Zero offset while the request sits below the floor
  sequence floor_req;
    o_amplitude_offset == 8'h00 && i_auto_scale < i_lower_threshold;
  endsequence
  a_low_bits_zero: assert property (i_rd |=> o_rdata[23:0] == 24'h0)
    else $error("low status bits set");
  a_read_holds: assert property (!i_rd |=> $stable(o_rdata))
    else $error("read data moved");
  a_unmapped_zero: assert property (i_rd && i_addr != 7'h6f |=> o_rdata == 32'h0)
    else $error("unmapped read not zero");
  a_offset_write: assert property (i_wr && i_addr == 7'h70 |=> o_amplitude_offset == $past(i_wdata))
    else $error("offset not written");
  a_pin_disables: assert property (i_driver_enable_low_pin [*5] |-> !o_bridge_enable)
    else $error("bridge on with pin high");
  a_off_time_off: assert property (i_chopper_off_time == 4'h0 |=> !o_bridge_enable)
    else $error("bridge on with zero off time");
  a_floor_zero: assert property (floor_req [*2] |=> o_pwm_amplitude == $past(i_lower_threshold))
    else $error("amplitude below floor");
  a_scale_pass: assert property ((o_amplitude_offset != 8'h00) [*2] |=> o_pwm_amplitude == $past(i_auto_scale))
    else $error("amplitude not passed");
  // Sync, flag and enable flops take four edges to turn the bridge off
  a_short_disables: assert property ((i_ground_short_a | i_ground_short_b) [*5] |-> !o_bridge_enable)
    else $error("bridge on with ground short");
  a_shutdown_off: assert property (i_overtemp_limit [*5] |-> !o_bridge_enable)
    else $error("bridge on at overtemperature");
endmodule // status_flags_asserts
bind driver_status_flags status_flags_asserts u_status_chk (.*);

// ### verif/host_model.sv
// Host model issuing register strobes
`timescale 1ns/100ps
module host_model (
  input  wire        i_mclk,
  input  wire [31:0] i_rdata,
  output reg         o_rd = 1'b0,
  output reg         o_wr = 1'b0,
  output reg  [6:0]  o_addr = 7'h00,
  output reg  [7:0]  o_wdata = 8'h00
);
  // One-cycle strobe; data is registered one edge later
  task rd(input [6:0] a, output [31:0] d);
    @(posedge i_mclk) #1 o_rd = 1'b1;
    o_addr = a;
    @(posedge i_mclk) #1 o_rd = 1'b0;
    d = i_rdata;
  endtask
  task wr(input [6:0] a, input [7:0] dat);
    @(posedge i_mclk) #1 o_wr = 1'b1;
    o_addr = a;
    o_wdata = dat;
    @(posedge i_mclk) #1 o_wr = 1'b0;
  endtask
endmodule // host_model

// ### verif/test_driver_status_flags.sv
// Self-checking bench of the driver status flags
`timescale 1ns/100ps
module test_driver_status_flags;
  reg         i_mclk = 0, i_rst = 1, i_step = 0, i_driver_enable_low_pin = 0, i_load_valid = 1;
  reg         i_open_load_a = 0, i_open_load_b = 0, i_ground_short_a = 0, i_ground_short_b = 0;
  reg         i_overtemp_warn = 0, i_overtemp_limit = 0, i_speed_mode = 0, i_speed_mode_stall = 0;
  reg  [9:0]  i_load_measurement_value = 10'h3ff;
  reg  [3:0]  i_chopper_off_time = 4'h3;
  reg  [7:0]  i_auto_scale = 8'h05, i_lower_threshold = 8'h09;
  wire        i_rd, i_wr, o_bridge_enable;
  wire [6:0]  i_addr;
  wire [7:0]  i_wdata, o_pwm_amplitude, o_amplitude_offset;
  wire [31:0] o_rdata;
  reg  [31:0] v;
  integer     n_fail = 0, n_compared = 0, cyc = 0, k;
  // Short count keeps the standstill wait small
  driver_status_flags #(.STANDSTILL_CYCLES(64)) i_driver_status_flags (.*);
  host_model i_host_model (.i_mclk(i_mclk), .i_rdata(o_rdata), .o_rd(i_rd), .o_wr(i_wr),
    .o_addr(i_addr), .o_wdata(i_wdata));
  always #25 i_mclk = ~i_mclk;
  // Hang guard, well above the run length
  always @(posedge i_mclk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      n_fail = n_fail + 1;
      test_done;
    end
  end
  task chk(input [31:0] got, exp, input string nm);
    n_compared = n_compared + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task wt(input integer n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask
  // Flags sit in the top byte, the rest reads zero
  task rs(input [7:0] f);
    i_host_model.rd(7'h6f, v);
    chk(v, {f, 24'h0}, "status");
  endtask
  task test_done;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    wt(5);
    i_rst = 0;
    chk(o_amplitude_offset, 8'h1e, "offset");
    repeat (6) begin
      i_step = 1;
      #200 i_step = 0;
      #200;
    end
    rs(8'h00);
    wt(50); rs(8'h00);
    wt(20); rs(8'h80);
    i_open_load_a = 1; wt(4); rs(8'ha0);
    i_open_load_b = 1; wt(4); rs(8'he0);
    chk(o_bridge_enable, 1, "bridge");
    i_open_load_a = 0; i_open_load_b = 0;
    // Short on A cleared by off time, short on B by the pin
    for (k = 0; k < 2; k = k + 1) begin
      {i_ground_short_b, i_ground_short_a} = k ? 2'b10 : 2'b01; wt(6);
      {i_ground_short_b, i_ground_short_a} = 2'b00; wt(4);
      rs(k ? 8'h90 : 8'h88);
      chk(o_bridge_enable, 0, "bridge");
      i_driver_enable_low_pin = k; i_chopper_off_time = k ? 4'h3 : 4'h0; wt(6);
      i_driver_enable_low_pin = 0; i_chopper_off_time = 4'h3; wt(4);
      rs(8'h80);
      chk(o_bridge_enable, 1, "bridge");
    end
    i_overtemp_warn = 1; wt(4); rs(8'h84);
    i_overtemp_limit = 1; wt(6); rs(8'h86);
    i_overtemp_limit = 0; wt(4); rs(8'h86);
    chk(o_bridge_enable, 0, "bridge");
    i_overtemp_warn = 0; wt(4); rs(8'h80);
    chk(o_bridge_enable, 1, "bridge");
    i_load_measurement_value = 0; wt(2); rs(8'h81);
    i_load_valid = 0; wt(2); rs(8'h80);
    i_load_valid = 1; i_load_measurement_value = 10'h001; wt(2); rs(8'h80);
    i_speed_mode = 1; wt(2); rs(8'h80);
    i_speed_mode_stall = 1; wt(2); rs(8'h81);
    i_host_model.rd(7'h6e, v); chk(v, 32'h0, "unmapped");
    i_host_model.wr(7'h70, 8'h00); wt(3);
    chk(o_pwm_amplitude, 8'h09, "pwm");
    i_host_model.wr(7'h70, 8'h03); wt(3);
    chk(o_pwm_amplitude, 8'h05, "pwm");
    test_done;
  end
endmodule // test_driver_status_flags
